// *** rtl/prs_map.vh ***
// Purpose: Register offsets, field positions, limits and timing counts.
// Assumes: APB byte addressing, one aligned 32-bit word per register.
// Notes:   Definitions only.
`ifndef PRS_MAP_VH
`define PRS_MAP_VH
// ==========================================================================
// Register byte offsets
`define PRS_OFS_CTRL      12'h000
`define PRS_OFS_STATUS    12'h004
`define PRS_OFS_EXT_SP    12'h008
`define PRS_OFS_IMIN_A    12'h00C
`define PRS_OFS_IMAX_A    12'h010
`define PRS_OFS_IMIN_B    12'h014
`define PRS_OFS_IMAX_B    12'h018
`define PRS_OFS_RAMP_UA   12'h01C
`define PRS_OFS_RAMP_DA   12'h020
`define PRS_OFS_RAMP_UB   12'h024
`define PRS_OFS_RAMP_DB   12'h028
`define PRS_OFS_DITHER    12'h02C
`define PRS_OFS_OFFSET    12'h030
`define PRS_OFS_WINDOW    12'h034
`define PRS_OFS_CUR_OUT   12'h038
`define PRS_OFS_FIX_BASE  12'h040
// ==========================================================================
// Control field positions
`define PRS_CTL_FIXSEL_LO 0
`define PRS_CTL_FIXSEL_HI 2
`define PRS_CTL_MODE_LO   4
`define PRS_CTL_MODE_HI   5
`define PRS_CTL_INV       8
`define PRS_CTL_ADJ_MIN   9
`define PRS_CTL_ADJ_MAX   10
`define PRS_CTL_STORE     16
// ==========================================================================
// Limits in steps of the stated resolution
`define PRS_PCT_FULL      11'h3E8
`define PRS_IMIN_MAX      9'h1DB
`define PRS_IMAX_MAX      10'h384
`define PRS_RAMP_MAX      10'h3FC
`define PRS_DLEVEL_MAX    7'h63
`define PRS_DFREQ_LAST    4'hC
`define PRS_OFS_LIM       8'h7C
`define PRS_WIN_MAX       7'h7C
`define PRS_MODE_OFFSET   2'h1
// ==========================================================================
// Timing
`define PRS_RAMP_STEP_NS  50000000
`define PRS_CLK_NS        40
`define PRS_TICK_CYC      (`PRS_RAMP_STEP_NS / `PRS_CLK_NS)
`endif

// *** rtl/prs_setpoint.v ***
// Purpose: Preset selection, ramping and current mapping for two solenoids.
// Assumes: APB slave on core_clk; nonvolatile store done by an outside engine.
// Notes:   Percent in 0.1% steps, currents in 2 mA steps.
// Overview of operation
// - Selected fixed preset overrides external preset.
// - Fixed presets in 0.1% steps, max 100%.
// - Positive drives solenoid A, negative B.
// - 0% maps Imin, 100% maps Imax.
// - Imin up to 950 mA, 2 mA.
// - Imax up to 1800 mA, 2 mA.
// - Adjusting Imin/Imax forces 0%/100% internally.
// - Dither frequency from thirteen fixed values.
// - Dither level up to 198 mA, 2 mA.
// - Offset only in mode 2, bounded.
// - Window width per input, bounded; the code keeps one window register for all inputs.
// - Linear ramp, separate up/down per solenoid.
// - Ramp up time full rise, 51 s.
// - Ramp down time full fall, 51 s.
// - Entered values quantised and clamped; a dither rate code above 12 is dropped, not clamped.
// - Store command saves all parameters.
// - Inversion swaps 0% and 100%.
// - Four operating modes, numbered 1 to 4.
//
// Design decisions made here: the register addresses and the APB register port.
`include "prs_map.vh"
`timescale 1ns/1ns
`default_nettype none
module prs_setpoint #(
    parameter TICK_CYC = `PRS_TICK_CYC
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        resetn,
    // APB
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Nonvolatile store engine
    output reg         store_req_ff,
    input  wire        store_done,
    // Solenoid current setpoints in 2 mA steps
    output reg  [9:0]  cur_a_ff,
    output reg  [9:0]  cur_b_ff,
    output reg         sol_a_on_ff,
    output reg         sol_b_on_ff,
    // Dither settings
    output wire [3:0]  dither_freq_sel,
    output wire [6:0]  dither_level
);
// ==========================================================================
// Registers
reg  [31:0] ctrl_ff;
reg  [11:0] ext_sp_ff;
reg  [8:0]  imin_a_ff, imin_b_ff;
reg  [9:0]  imax_a_ff, imax_b_ff;
reg  [9:0]  ramp_ua_ff, ramp_da_ff, ramp_ub_ff, ramp_db_ff;
reg  [3:0]  dfreq_ff;
reg  [6:0]  dlevel_ff;
reg  [7:0]  offset_ff;
reg  [6:0]  win_ff;
reg  [11:0] fix_ff [0:6];
reg  [31:0] rd;
reg         hit;
integer     i;

wire        wr = psel & penable & pwrite;
wire [2:0]  fixsel = ctrl_ff[`PRS_CTL_FIXSEL_HI:`PRS_CTL_FIXSEL_LO];
wire [1:0]  mode = ctrl_ff[`PRS_CTL_MODE_HI:`PRS_CTL_MODE_LO];
wire [3:0]  fix_idx = paddr[5:2];
// Fixed values sit one word apart; a slot past the seventh is unmapped.
wire        fix_hit = (paddr[11:6] == 6'h01) && (fix_idx < 4'h7);

assign pready = 1'b1;
assign pslverr = psel & penable & ~hit;
assign prdata = (psel & ~pwrite) ? rd : 32'h0;
assign dither_freq_sel = dfreq_ff;
assign dither_level = dlevel_ff;

// Magnitude clamp of a signed 0.1% value to full scale.
function [11:0] clamp_pct;
    input [31:0] v;
    reg   [31:0] m;
    begin
        m = v[31] ? (~v + 32'h1) : v;
        if (m > {21'h0, `PRS_PCT_FULL})
            m = {21'h0, `PRS_PCT_FULL};
        clamp_pct = v[31] ? (~m[11:0] + 12'h1) : m[11:0];
    end
endfunction

function [9:0] clamp10;
    input [31:0] v;
    input [9:0]  lim;
    begin
        clamp10 = (v > {22'h0, lim}) ? lim : v[9:0];
    end
endfunction

// Clamped write values, cut to the width of their registers.
wire [9:0]  imin_wr = clamp10(pwdata, {1'b0, `PRS_IMIN_MAX});
wire [31:0] ofs_mag = pwdata[31] ? (~pwdata + 32'h1) : pwdata;

// ==========================================================================
// Register writes
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        ctrl_ff    <= 32'h0;
        ext_sp_ff  <= 12'h0;
        imin_a_ff  <= 9'h0;
        imin_b_ff  <= 9'h0;
        imax_a_ff  <= 10'h0;
        imax_b_ff  <= 10'h0;
        ramp_ua_ff <= 10'h0;
        ramp_da_ff <= 10'h0;
        ramp_ub_ff <= 10'h0;
        ramp_db_ff <= 10'h0;
        dfreq_ff   <= 4'h0;
        dlevel_ff  <= 7'h0;
        offset_ff  <= 8'h0;
        win_ff     <= 7'h0;
        for (i = 0; i < 7; i = i + 1)
            fix_ff[i] <= 12'h0;
    end else if (wr) begin
        case (paddr)
        `PRS_OFS_CTRL: begin
            ctrl_ff <= {21'h0, pwdata[10:8], 2'h0, pwdata[5:4], 1'b0,
                        pwdata[2:0]};
        end
        `PRS_OFS_EXT_SP:  ext_sp_ff <= clamp_pct(pwdata);
        `PRS_OFS_IMIN_A:  imin_a_ff <= imin_wr[8:0];
        `PRS_OFS_IMAX_A:  imax_a_ff <= clamp10(pwdata, `PRS_IMAX_MAX);
        `PRS_OFS_IMIN_B:  imin_b_ff <= imin_wr[8:0];
        `PRS_OFS_IMAX_B:  imax_b_ff <= clamp10(pwdata, `PRS_IMAX_MAX);
        `PRS_OFS_RAMP_UA: ramp_ua_ff <= clamp10(pwdata, `PRS_RAMP_MAX);
        `PRS_OFS_RAMP_DA: ramp_da_ff <= clamp10(pwdata, `PRS_RAMP_MAX);
        `PRS_OFS_RAMP_UB: ramp_ub_ff <= clamp10(pwdata, `PRS_RAMP_MAX);
        `PRS_OFS_RAMP_DB: ramp_db_ff <= clamp10(pwdata, `PRS_RAMP_MAX);
        `PRS_OFS_DITHER: begin
            // An unlisted rate code is dropped, so the dither keeps its last rate.
            if (pwdata[3:0] <= `PRS_DFREQ_LAST)
                dfreq_ff <= pwdata[3:0];
            if (pwdata[14:8] > `PRS_DLEVEL_MAX)
                dlevel_ff <= `PRS_DLEVEL_MAX;
            else
                dlevel_ff <= pwdata[14:8];
        end
        `PRS_OFS_OFFSET: begin
            // Offset is locked outside mode 2 so stale trims cannot creep in.
            if (mode == `PRS_MODE_OFFSET) begin
                if (!pwdata[31] && ofs_mag > {24'h0, `PRS_OFS_LIM})
                    offset_ff <= `PRS_OFS_LIM;
                else if (pwdata[31] && ofs_mag > {24'h0, `PRS_OFS_LIM})
                    offset_ff <= ~`PRS_OFS_LIM + 8'h1;
                else
                    offset_ff <= pwdata[7:0];
            end
        end
        `PRS_OFS_WINDOW: begin
            if (pwdata > {25'h0, `PRS_WIN_MAX})
                win_ff <= `PRS_WIN_MAX;
            else
                win_ff <= pwdata[6:0];
        end
        default: begin
            if (fix_hit)
                fix_ff[fix_idx[2:0]] <= clamp_pct(pwdata);
        end
        endcase
    end
end

// ==========================================================================
// Store request: set by the command, cleared by the engine.
// Set wins over clear so a command in the done cycle is not lost.
always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
        store_req_ff <= 1'b0;
    else if (wr && paddr == `PRS_OFS_CTRL && pwdata[`PRS_CTL_STORE])
        store_req_ff <= 1'b1;
    else if (store_done)
        store_req_ff <= 1'b0;
end

// ==========================================================================
// Preset selection
// Code 0 picks the external input; fixed values are numbered from one.
wire [11:0] sel_sp  = (fixsel != 3'h0) ? fix_ff[fixsel - 3'h1] : ext_sp_ff;
wire        sel_neg = sel_sp[11];
wire [11:0] sel_mag = sel_neg ? (~sel_sp + 12'h1) : sel_sp;
wire [10:0] tgt_a = sel_neg ? 11'h0 : sel_mag[10:0];
wire [10:0] tgt_b = sel_neg ? sel_mag[10:0] : 11'h0;

// ==========================================================================
// Ramp tick
// A shorter TICK_CYC only speeds up simulation; ramp units stay one tick.
reg [31:0] tick_cnt_ff;
wire       tick = (tick_cnt_ff == TICK_CYC - 1);
always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
        tick_cnt_ff <= 32'h0;
    else
        tick_cnt_ff <= tick ? 32'h0 : tick_cnt_ff + 32'h1;
end

// Ramp state per solenoid in 0.1% units scaled by 1024 for fractional steps.
reg  [20:0] pos_a_ff, pos_b_ff;
reg  [20:0] nxt_pos_a, nxt_pos_b;

function [20:0] ramp_step;
    input [20:0] pos;
    input [10:0] tgt;
    input [9:0]  t_up;
    input [9:0]  t_dn;
    reg   [20:0] goal;
    reg   [20:0] inc;
    begin
        goal = {tgt, 10'h0};
        if (pos < goal) begin
            inc = (t_up == 10'h0) ? 21'h1FFFFF
                : ({`PRS_PCT_FULL, 10'h0} / {11'h0, t_up});
            ramp_step = (t_up == 10'h0 || goal - pos <= inc) ? goal : pos + inc;
        end else begin
            inc = (t_dn == 10'h0) ? 21'h1FFFFF
                : ({`PRS_PCT_FULL, 10'h0} / {11'h0, t_dn});
            ramp_step = (t_dn == 10'h0 || pos - goal <= inc) ? goal : pos - inc;
        end
    end
endfunction

always @* begin
    nxt_pos_a = pos_a_ff;
    nxt_pos_b = pos_b_ff;
    if (tick) begin
        nxt_pos_a = ramp_step(pos_a_ff, tgt_a, ramp_ua_ff, ramp_da_ff);
        nxt_pos_b = ramp_step(pos_b_ff, tgt_b, ramp_ub_ff, ramp_db_ff);
    end
end

always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        pos_a_ff <= 21'h0;
        pos_b_ff <= 21'h0;
    end else begin
        pos_a_ff <= nxt_pos_a;
        pos_b_ff <= nxt_pos_b;
    end
end

// Ramp is busy until both channels sit exactly on their targets.
wire        busy_a = (pos_a_ff != {tgt_a, 10'h0});
wire        busy_b = (pos_b_ff != {tgt_b, 10'h0});

// ==========================================================================
// Current mapping
// A span with Imax below Imin collapses to Imin rather than wrapping.
function [9:0] map_cur;
    input [10:0] pct;
    input        on;
    input        inv;
    input        adj_min;
    input        adj_max;
    input [8:0]  imin;
    input [9:0]  imax;
    reg   [10:0] p;
    reg   [21:0] span;
    begin
        p = inv ? (`PRS_PCT_FULL - pct) : pct;
        if (adj_min)
            p = 11'h0;
        else if (adj_max)
            p = `PRS_PCT_FULL;
        span = (imax > {1'b0, imin}) ? ({12'h0, imax} - {13'h0, imin}) : 22'h0;
        span = (span * {11'h0, p}) / {11'h0, `PRS_PCT_FULL};
        map_cur = (on | adj_min | adj_max) ? ({1'b0, imin} + span[9:0]) : 10'h0;
    end
endfunction

wire [10:0] eff_a = pos_a_ff[20:10];
wire [10:0] eff_b = pos_b_ff[20:10];
wire        inv = ctrl_ff[`PRS_CTL_INV];
wire        amin = ctrl_ff[`PRS_CTL_ADJ_MIN];
wire        amax = ctrl_ff[`PRS_CTL_ADJ_MAX];
// At a zero ramp level, A stays powered for a non-negative preset; B for a negative one only when inverted.
wire        on_a = (eff_a != 11'h0) | (~sel_neg & ~inv) | (inv & ~sel_neg);
wire        on_b = (eff_b != 11'h0) | (sel_neg & inv) | (inv & sel_neg);

wire [9:0]  nxt_cur_a = map_cur(eff_a, on_a, inv, amin, amax, imin_a_ff, imax_a_ff);
wire [9:0]  nxt_cur_b = map_cur(eff_b, on_b, inv, amin, amax, imin_b_ff, imax_b_ff);
wire        nxt_on_a  = on_a | amin | amax;
wire        nxt_on_b  = on_b | amin | amax;

always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        cur_a_ff    <= 10'h0;
        cur_b_ff    <= 10'h0;
        sol_a_on_ff <= 1'b0;
        sol_b_on_ff <= 1'b0;
    end else begin
        cur_a_ff    <= nxt_cur_a;
        cur_b_ff    <= nxt_cur_b;
        sol_a_on_ff <= nxt_on_a;
        sol_b_on_ff <= nxt_on_b;
    end
end

// ==========================================================================
// Read mux
// Unmapped reads return zero and raise pslverr instead of aliasing.
always @* begin
    rd  = 32'h0;
    hit = 1'b1;
    case (paddr)
    `PRS_OFS_CTRL:    rd = ctrl_ff;
    `PRS_OFS_STATUS:  rd = {30'h0, busy_a | busy_b, store_req_ff};
    `PRS_OFS_EXT_SP:  rd = {{20{ext_sp_ff[11]}}, ext_sp_ff};
    `PRS_OFS_IMIN_A:  rd = {23'h0, imin_a_ff};
    `PRS_OFS_IMAX_A:  rd = {22'h0, imax_a_ff};
    `PRS_OFS_IMIN_B:  rd = {23'h0, imin_b_ff};
    `PRS_OFS_IMAX_B:  rd = {22'h0, imax_b_ff};
    `PRS_OFS_RAMP_UA: rd = {22'h0, ramp_ua_ff};
    `PRS_OFS_RAMP_DA: rd = {22'h0, ramp_da_ff};
    `PRS_OFS_RAMP_UB: rd = {22'h0, ramp_ub_ff};
    `PRS_OFS_RAMP_DB: rd = {22'h0, ramp_db_ff};
    `PRS_OFS_DITHER:  rd = {17'h0, dlevel_ff, 4'h0, dfreq_ff};
    `PRS_OFS_OFFSET:  rd = {{24{offset_ff[7]}}, offset_ff};
    `PRS_OFS_WINDOW:  rd = {25'h0, win_ff};
    `PRS_OFS_CUR_OUT: rd = {6'h0, cur_b_ff, 6'h0, cur_a_ff};
    default: begin
        if (fix_hit)
            rd = {{20{fix_ff[fix_idx[2:0]][11]}}, fix_ff[fix_idx[2:0]]};
        else
            hit = 1'b0;
    end
    endcase
end

endmodule
`default_nettype wire

// *** sim/prs_nvm_model.sv ***
// Purpose: Behavioural nonvolatile store engine facing the setpoint block.
// Assumes: Request is a level held until done is seen.
// Notes:   LAT sets how slowly the engine answers.
`timescale 1ns/1ns
`default_nettype none
module prs_nvm_model #(
    parameter int LAT = 5
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic store_req,
    output var  logic store_done
);
    int cnt;
    // ======================================================================
    // One done pulse after LAT+1 busy cycles, so a pending state is visible.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
            store_done <= 1'b0;
        end else begin
            store_done <= 1'b0;
            if (store_req && !store_done) begin
                cnt <= (cnt == LAT) ? 0 : cnt + 1;
                store_done <= (cnt == LAT);
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/prs_setpoint_checker.sv ***
// Purpose: Port assertions for the setpoint block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ns
`default_nettype none
module prs_setpoint_checker (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        store_req_ff,
    input wire logic        store_done,
    input wire logic [9:0]  cur_a_ff,
    input wire logic [9:0]  cur_b_ff,
    input wire logic        sol_a_on_ff,
    input wire logic        sol_b_on_ff,
    input wire logic [3:0]  dither_freq_sel,
    input wire logic [6:0]  dither_level
);
    wire acc      = psel && penable && pwrite;
    wire store_wr = acc && paddr == 12'h000 && pwdata[16];
    wire dith_wr  = acc && paddr == 12'h02C;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ======================================================================
    // Store request steps.
    sequence s_store_cmd;
        store_wr;
    endsequence
    sequence s_store_ack;
        store_req_ff && store_done;
    endsequence
    a_store_set: assert property (s_store_cmd |=> store_req_ff)
        else $error("store request not raised");
    a_store_hold: assert property (store_req_ff && !store_done |=> store_req_ff)
        else $error("store request dropped early");
    a_store_clear: assert property (s_store_ack ##0 !store_wr |=> !store_req_ff)
        else $error("store request not cleared");
    a_cur_a_max: assert property (cur_a_ff <= 10'h384)
        else $error("current A above range");
    a_cur_b_max: assert property (cur_b_ff <= 10'h384)
        else $error("current B above range");
    a_off_a_zero: assert property (!sol_a_on_ff |-> cur_a_ff == 10'h000)
        else $error("idle solenoid A has current");
    a_off_b_zero: assert property (!sol_b_on_ff |-> cur_b_ff == 10'h000)
        else $error("idle solenoid B has current");
    a_dither_take: assert property (dith_wr && pwdata[3:0] <= 4'hC
        |=> dither_freq_sel == $past(pwdata[3:0]))
        else $error("dither frequency not taken");
    a_dither_keep: assert property (dith_wr && pwdata[3:0] > 4'hC
        |=> $stable(dither_freq_sel))
        else $error("illegal dither frequency taken");
    a_dither_lvl: assert property (dither_level <= 7'h63)
        else $error("dither level above range");
    a_idle_rdata: assert property (!psel |-> prdata == 32'h0 && pready)
        else $error("bus idle output wrong");
endmodule
`default_nettype wire
bind prs_setpoint prs_setpoint_checker prs_setpoint_checker_inst (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .store_req_ff(store_req_ff), .store_done(store_done),
    .cur_a_ff(cur_a_ff), .cur_b_ff(cur_b_ff), .sol_a_on_ff(sol_a_on_ff),
    .sol_b_on_ff(sol_b_on_ff), .dither_freq_sel(dither_freq_sel),
    .dither_level(dither_level));

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the setpoint block.
// Assumes: Zero-wait APB slave, tick shortened to four cycles.
// Notes:   Ramp timing checked by differences, not absolute phase.
`include "prs_map.vh"
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        core_clk, resetn, psel, penable, pwrite, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdat;
    logic [9:0]  c1;
    wire  [31:0] prdata;
    wire         pready, pslverr, store_req_ff, store_done, sol_a_on_ff, sol_b_on_ff;
    wire  [9:0]  cur_a_ff, cur_b_ff;
    wire  [3:0]  dither_freq_sel;
    wire  [6:0]  dither_level;
    int          num_errors, total_checks, cycles;
    prs_setpoint #(.TICK_CYC(4)) prs_setpoint_inst (.core_clk(core_clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .store_req_ff(store_req_ff),
        .store_done(store_done), .cur_a_ff(cur_a_ff), .cur_b_ff(cur_b_ff),
        .sol_a_on_ff(sol_a_on_ff), .sol_b_on_ff(sol_b_on_ff),
        .dither_freq_sel(dither_freq_sel), .dither_level(dither_level));
    prs_nvm_model #(.LAT(5)) prs_nvm_model_inst (.core_clk(core_clk), .resetn(resetn),
        .store_req(store_req_ff), .store_done(store_done));
    // ======================================================================
    // Bus and compare tasks.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    task settle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // ======================================================================
    // Scenarios.
    task t_limits;
        rd(`PRS_OFS_IMIN_A, 32'h0);
        wr(`PRS_OFS_IMIN_A, 32'h258); rd(`PRS_OFS_IMIN_A, 32'h1DB);
        wr(`PRS_OFS_IMAX_B, 32'h3E8); rd(`PRS_OFS_IMAX_B, 32'h384);
        wr(`PRS_OFS_RAMP_UB, 32'h7D0); rd(`PRS_OFS_RAMP_UB, 32'h3FC);
        wr(`PRS_OFS_RAMP_DB, 32'h7D0); rd(`PRS_OFS_RAMP_DB, 32'h3FC);
        wr(`PRS_OFS_FIX_BASE, 32'h5DC); rd(`PRS_OFS_FIX_BASE, 32'h3E8);
        wr(`PRS_OFS_DITHER, 32'h7805); rd(`PRS_OFS_DITHER, 32'h6305);
        chk(dither_level, 32'h63);
        for (int i = 0; i < 14; i++) begin
            wr(`PRS_OFS_DITHER, i);
            rd(`PRS_OFS_DITHER, (i > 12) ? 12 : i);
            chk(dither_freq_sel, (i > 12) ? 12 : i);
        end
        rd(12'h03C, 32'h0);
        chk(rerr, 1'b1);
        $display("test limits done");
    endtask
    task t_modes;
        for (int m = 0; m < 4; m++) begin
            wr(`PRS_OFS_CTRL, m << 4);
            rd(`PRS_OFS_CTRL, m << 4);
            wr(`PRS_OFS_OFFSET, m + 1);
            rd(`PRS_OFS_OFFSET, (m > 0) ? 2 : 0);
        end
        wr(`PRS_OFS_CTRL, 32'h10);
        wr(`PRS_OFS_OFFSET, 32'hC8); rd(`PRS_OFS_OFFSET, 32'h7C);
        wr(`PRS_OFS_WINDOW, 32'hC8); rd(`PRS_OFS_WINDOW, 32'h7C);
        $display("test modes done");
    endtask
    task t_map;
        wr(`PRS_OFS_RAMP_UB, 0); wr(`PRS_OFS_RAMP_DB, 0);
        wr(`PRS_OFS_IMIN_A, 100); wr(`PRS_OFS_IMAX_A, 600);
        wr(`PRS_OFS_IMIN_B, 50); wr(`PRS_OFS_IMAX_B, 300);
        wr(`PRS_OFS_EXT_SP, -1000); wr(`PRS_OFS_FIX_BASE, 500);
        wr(`PRS_OFS_CTRL, 32'h1); settle(12);
        chk({sol_a_on_ff, sol_b_on_ff, cur_a_ff}, {2'b10, 10'd350});
        wr(`PRS_OFS_FIX_BASE, -1000); settle(12);
        chk({sol_a_on_ff, sol_b_on_ff, cur_b_ff}, {2'b01, 10'd300});
        rd(`PRS_OFS_CUR_OUT, 300 << 16);
        wr(`PRS_OFS_FIX_BASE, 200); wr(`PRS_OFS_CTRL, 32'h101); settle(12);
        chk(cur_a_ff, 500);
        wr(`PRS_OFS_CTRL, 32'h200); settle(12);
        chk({cur_a_ff, cur_b_ff}, {10'd100, 10'd50});
        wr(`PRS_OFS_CTRL, 32'h400); settle(12);
        chk({cur_a_ff, cur_b_ff}, {10'd600, 10'd300});
        $display("test map done");
    endtask
    task t_ramp;
        wr(`PRS_OFS_RAMP_UA, 4); wr(`PRS_OFS_FIX_BASE + 4, 0);
        wr(`PRS_OFS_CTRL, 32'h2); settle(12);
        wr(`PRS_OFS_FIX_BASE + 4, 1000); settle(6);
        c1 = cur_a_ff;
        settle(4);
        chk(cur_a_ff - c1, 125);
        rd(`PRS_OFS_STATUS, 32'h2);
        settle(30);
        chk(cur_a_ff, 600);
        wr(`PRS_OFS_FIX_BASE + 4, 500); settle(12);
        chk(cur_a_ff, 350);
        $display("test ramp done");
    endtask
    task t_store;
        wr(`PRS_OFS_CTRL, 32'h10002);
        rd(`PRS_OFS_STATUS, 32'h1);
        settle(20);
        rd(`PRS_OFS_STATUS, 32'h0);
        $display("test store done");
    endtask
    task finish_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ======================================================================
    // Clock, watchdog and main sequence.
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            finish_test;
        end
    end
    initial begin
        resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        t_limits;
        t_modes;
        t_map;
        t_ramp;
        t_store;
        finish_test;
    end
endmodule
`default_nettype wire
